// *** verilog/tef_flags.sv ***
// Timer event and interrupt status flags with mask and interrupt output
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module tef_flags (
    input wire logic clk, // 10 MHz clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire tef_pkg::tef_bus_req_type bus_req, // Register bus request
    output logic [tef_pkg::DATA_W-1:0] bus_rdata, // Read data, cycle after read
    input wire tef_pkg::tef_timer_evt_type timer_evt, // Timer-wide events
    input wire tef_pkg::tef_chan_evt_type chan_evt, // Channel events
    input wire logic [4*tef_pkg::VALUE_W-1:0] chan_value, // Capture values, ch0 low
    output logic irq // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Full-width compare, so no offset aliases onto a mapped register
    function automatic logic addr_hit(
        input logic [tef_pkg::ADDR_W-1:0] addr,
        input logic [tef_pkg::ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction : addr_hit

    // One capture value lane out of the packed channel bus
    function automatic logic [tef_pkg::VALUE_W-1:0] value_lane(
        input logic [4*tef_pkg::VALUE_W-1:0] values,
        input int ch
    );
        return values[ch*tef_pkg::VALUE_W +: tef_pkg::VALUE_W];
    endfunction : value_lane

    // Keeps only the bits that exist in the flag and mask layout
    function automatic logic [tef_pkg::DATA_W-1:0] implemented(
        input logic [tef_pkg::DATA_W-1:0] word
    );
        return word & tef_pkg::FLAGS_IMPL;
    endfunction : implemented

    // Sticky update: the set term goes last, so an event beats a clear
    function automatic logic [tef_pkg::DATA_W-1:0] sticky_next(
        input logic [tef_pkg::DATA_W-1:0] cur,
        input logic [tef_pkg::DATA_W-1:0] set_bits,
        input logic [tef_pkg::DATA_W-1:0] clr_bits
    );
        return set_bits | (cur & ~clr_bits);
    endfunction : sticky_next

    // Pending and enabled within one group of channel flags
    function automatic logic group_pending(
        input logic [tef_pkg::NUM_CH-1:0] flags,
        input logic [tef_pkg::NUM_CH-1:0] enables
    );
        return |(flags & enables);
    endfunction : group_pending

    ////////////////////////////////////////////////////////////////////////////
    // Register map

    // 0x07c timer_event_flags: sticky, write 0 clears, write 1 keeps
    // 0x0c0 event mask: same layout, read and write, 1 enables the interrupt
    // 0x090 to 0x09c: channel 0 to 3 capture values, read only, low half
    // Any other offset: writes ignored, reads return zero

    // Flag layout
    //   [12] second_break_flag
    //   [11] first_break_flag
    //   [10] trigger_event_flag
    //   [9] update_two_flag
    //   [8] update_one_flag
    //   [7:4] over-capture flags of channels 3 to 0
    //   [3:0] capture/compare flags of channels 3 to 0
    //   [31:13] reserved, read zero

    // Timing
    // A flag reads back from the cycle after its event, and irq rises at the same edge
    // Read data stand only in the cycle after the read strobe
    // A read in the cycle of an event returns the old word; software must poll again

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic [tef_pkg::DATA_W-1:0] flags_q;
    logic [tef_pkg::DATA_W-1:0] flags_d;
    logic [tef_pkg::DATA_W-1:0] mask_q;
    logic [tef_pkg::DATA_W-1:0] rdata_q;
    logic [tef_pkg::DATA_W-1:0] rdata_d;
    logic trig_prev_q;

    // Named views of the stored flags
    wire second_break_flag = flags_q[tef_pkg::BIT_SECOND_BREAK];
    wire first_break_flag = flags_q[tef_pkg::BIT_FIRST_BREAK];
    wire trigger_event_flag = flags_q[tef_pkg::BIT_TRIGGER];
    wire update_two_flag = flags_q[tef_pkg::BIT_UPDATE_TWO];
    wire update_one_flag = flags_q[tef_pkg::BIT_UPDATE_ONE];
    wire [tef_pkg::NUM_CH-1:0] overcap_flags =
        flags_q[tef_pkg::BIT_CH0_OVERCAP +: tef_pkg::NUM_CH];
    wire [tef_pkg::NUM_CH-1:0] capcomp_flags =
        flags_q[tef_pkg::BIT_CH0_CAPCOMP +: tef_pkg::NUM_CH];

    // Matching interrupt enables
    wire [tef_pkg::NUM_CH-1:0] overcap_enables =
        mask_q[tef_pkg::BIT_CH0_OVERCAP +: tef_pkg::NUM_CH];
    wire [tef_pkg::NUM_CH-1:0] capcomp_enables =
        mask_q[tef_pkg::BIT_CH0_CAPCOMP +: tef_pkg::NUM_CH];

    // Register selects
    wire hit_flags = addr_hit(bus_req.addr, tef_pkg::OFS_EVENT_FLAGS);
    wire hit_mask = addr_hit(bus_req.addr, tef_pkg::OFS_EVENT_MASK);
    wire hit_ch0 = addr_hit(bus_req.addr, tef_pkg::OFS_CH0_VALUE);
    wire hit_ch1 = addr_hit(bus_req.addr, tef_pkg::OFS_CH1_VALUE);
    wire hit_ch2 = addr_hit(bus_req.addr, tef_pkg::OFS_CH2_VALUE);
    wire hit_ch3 = addr_hit(bus_req.addr, tef_pkg::OFS_CH3_VALUE);
    wire [tef_pkg::NUM_CH-1:0] hit_value = {hit_ch3, hit_ch2, hit_ch1, hit_ch0};

    // Strobes qualified by their register
    wire wr_flags = bus_req.wr && hit_flags;
    wire wr_mask = bus_req.wr && hit_mask;
    wire rd_flags = bus_req.rd && hit_flags;
    wire rd_mask = bus_req.rd && hit_mask;
    wire [tef_pkg::NUM_CH-1:0] rd_value = {tef_pkg::NUM_CH{bus_req.rd}} & hit_value;

    ////////////////////////////////////////////////////////////////////////////
    // Set terms

    // Edge against last cycle's level; the trigger is on this clock, so no synchroniser
    wire trig_rise = timer_evt.slave_trigger_input && !trig_prev_q;
    wire upd_wrap = timer_evt.counter_wrap;
    wire upd_gen = timer_evt.update_one_generate && !timer_evt.update_disable;
    wire upd_slave = trig_rise && timer_evt.slave_restart_mode && !timer_evt.update_disable;

    // Compare matches count only in edge-aligned counting
    wire edge_aligned = !chan_evt.center_aligned;

    wire [tef_pkg::NUM_CH-1:0] cap_in;
    wire [tef_pkg::NUM_CH-1:0] match_out;
    wire [tef_pkg::NUM_CH-1:0] capcomp_set;
    wire [tef_pkg::NUM_CH-1:0] overcap_set;
    wire [tef_pkg::NUM_CH-1:0] rd_clr;

    for (genvar ch = 0; ch < tef_pkg::NUM_CH; ch++) begin : g_chan
        assign cap_in[ch] = chan_evt.capture[ch] && chan_evt.is_input[ch];
        assign match_out[ch] = chan_evt.compare_match[ch] && !chan_evt.is_input[ch]
                               && edge_aligned;
        assign capcomp_set[ch] = cap_in[ch] || match_out[ch];
        assign overcap_set[ch] = cap_in[ch] && capcomp_flags[ch];
        assign rd_clr[ch] = rd_value[ch] && chan_evt.is_input[ch];
    end

    wire set_second_break = timer_evt.second_break;
    wire set_first_break = timer_evt.first_break;
    wire set_trigger = timer_evt.trigger;
    wire set_update_two = timer_evt.update_two;
    wire set_update_one = upd_wrap || upd_gen || upd_slave;

    // Flag positions are spread out, so the vector is built field by field
    logic [tef_pkg::DATA_W-1:0] set_vec;
    always_comb begin
        set_vec = '0;
        set_vec[tef_pkg::BIT_CH0_CAPCOMP +: tef_pkg::NUM_CH] = capcomp_set;
        set_vec[tef_pkg::BIT_CH0_OVERCAP +: tef_pkg::NUM_CH] = overcap_set;
        set_vec[tef_pkg::BIT_UPDATE_ONE] = set_update_one;
        set_vec[tef_pkg::BIT_UPDATE_TWO] = set_update_two;
        set_vec[tef_pkg::BIT_TRIGGER] = set_trigger;
        set_vec[tef_pkg::BIT_FIRST_BREAK] = set_first_break;
        set_vec[tef_pkg::BIT_SECOND_BREAK] = set_second_break;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear terms

    wire [tef_pkg::DATA_W-1:0] sw_clr = wr_flags ? ~bus_req.wdata : '0;
    logic [tef_pkg::DATA_W-1:0] clr_vec;
    always_comb begin
        clr_vec = sw_clr;
        clr_vec[tef_pkg::BIT_CH0_CAPCOMP +: tef_pkg::NUM_CH] =
            sw_clr[tef_pkg::BIT_CH0_CAPCOMP +: tef_pkg::NUM_CH] | rd_clr;
    end

    assign flags_d = implemented(sticky_next(flags_q, set_vec, clr_vec));

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire [tef_pkg::DATA_W-1:0] flags_word = implemented(flags_q);
    wire [tef_pkg::DATA_W-1:0] mask_word = implemented(mask_q);

    // Selects are one-hot, so the loop order does not matter
    logic [tef_pkg::VALUE_W-1:0] value_sel;
    always_comb begin
        value_sel = '0;
        for (int i = 0; i < tef_pkg::NUM_CH; i++) begin
            if (rd_value[i]) begin
                value_sel = value_lane(chan_value, i);
            end
        end
    end
    wire [tef_pkg::DATA_W-1:0] value_word = {{(tef_pkg::DATA_W-tef_pkg::VALUE_W){1'h0}}, value_sel};

    // Idle cycles and unmapped offsets give zero, so read data stand one cycle only
    always_comb begin
        rdata_d = '0;
        if (rd_flags) begin
            rdata_d = flags_word;
        end else if (rd_mask) begin
            rdata_d = mask_word;
        end else if (|rd_value) begin
            rdata_d = value_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Flags; the reset branch loads constants only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= tef_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Mask: same layout as the flags, unimplemented bits stay zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= tef_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= implemented(bus_req.wdata);
        end
    end

    // Read data stand one cycle, then fall back to zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Trigger history resets low, the idle level, so a line held high at release edges once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_prev_q <= 1'h0;
        end else begin
            trig_prev_q <= timer_evt.slave_trigger_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign bus_rdata = rdata_q;

    // Pending and enabled, one term per timer-wide source and one per channel group
    wire irq_second_break = second_break_flag && mask_q[tef_pkg::BIT_SECOND_BREAK];
    wire irq_first_break = first_break_flag && mask_q[tef_pkg::BIT_FIRST_BREAK];
    wire irq_trigger = trigger_event_flag && mask_q[tef_pkg::BIT_TRIGGER];
    wire irq_update_two = update_two_flag && mask_q[tef_pkg::BIT_UPDATE_TWO];
    wire irq_update_one = update_one_flag && mask_q[tef_pkg::BIT_UPDATE_ONE];
    wire irq_overcap = group_pending(overcap_flags, overcap_enables);
    wire irq_capcomp = group_pending(capcomp_flags, capcomp_enables);

    // Level interrupt follows the registered flags, so it lags an event by one edge
    assign irq = irq_second_break || irq_first_break || irq_trigger || irq_update_two
                 || irq_update_one || irq_overcap || irq_capcomp;

endmodule : tef_flags

// *** verilog/tef_pkg.sv ***
// Package: register map, flag layout and event carriers of the timer event flags
package tef_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned VALUE_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 12'h07c;
    localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 12'h0c0;
    localparam logic [ADDR_W-1:0] OFS_CH0_VALUE = 12'h090;
    localparam logic [ADDR_W-1:0] OFS_CH1_VALUE = 12'h094;
    localparam logic [ADDR_W-1:0] OFS_CH2_VALUE = 12'h098;
    localparam logic [ADDR_W-1:0] OFS_CH3_VALUE = 12'h09c;

    // Flag bit positions
    localparam int unsigned BIT_CH0_CAPCOMP = 0;
    localparam int unsigned BIT_CH0_OVERCAP = 4;
    localparam int unsigned BIT_UPDATE_ONE = 8;
    localparam int unsigned BIT_UPDATE_TWO = 9;
    localparam int unsigned BIT_TRIGGER = 10;
    localparam int unsigned BIT_FIRST_BREAK = 11;
    localparam int unsigned BIT_SECOND_BREAK = 12;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
    // Bits that exist in the flag and mask registers; the rest read zero
    localparam logic [DATA_W-1:0] FLAGS_IMPL = 32'h0000_1fff;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tef_bus_req_type;

    // Timer-wide events, one-cycle pulses except the levels noted
    typedef struct packed {
        logic second_break;
        logic first_break;
        logic trigger;
        logic update_two;
        logic counter_wrap;
        logic update_one_generate;
        logic update_disable;       // Level
        logic slave_restart_mode;   // Level
        logic slave_trigger_input;  // Level, edge taken inside
    } tef_timer_evt_type;

    // Per-channel events
    typedef struct packed {
        logic [NUM_CH-1:0] is_input;      // Level
        logic [NUM_CH-1:0] capture;       // Pulse
        logic [NUM_CH-1:0] compare_match; // Pulse
        logic center_aligned;             // Level
    } tef_chan_evt_type;

endpackage : tef_pkg

// *** verification/tef_flags_sva.sv ***
// Assertion checker for the timer event flags block
`timescale 1ns/1ps
module tef_flags_sva (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire tef_pkg::tef_bus_req_type bus_req, // Bus request
    input wire logic [tef_pkg::DATA_W-1:0] bus_rdata, // Read data
    input wire tef_pkg::tef_timer_evt_type timer_evt, // Timer events
    input wire tef_pkg::tef_chan_evt_type chan_evt, // Channel events
    input wire logic [4*tef_pkg::VALUE_W-1:0] chan_value, // Capture values
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire rf = bus_req.rd && bus_req.addr == tef_pkg::OFS_EVENT_FLAGS;
    wire rv0 = bus_req.rd && bus_req.addr == tef_pkg::OFS_CH0_VALUE;
    wire cap0 = chan_evt.capture[0] && chan_evt.is_input[0];
    // A pulse shows in a flag read issued the cycle after; no write can slip between
    property setp(e, int b);
        e ##1 rf |=> bus_rdata[b];
    endproperty
    AST_BRK2: assert property (setp(timer_evt.second_break, 12))
        else $error("flag 12 not set");
    AST_BRK1: assert property (setp(timer_evt.first_break, 11))
        else $error("flag 11 not set");
    AST_TRIG: assert property (setp(timer_evt.trigger, 10))
        else $error("flag 10 not set");
    AST_UPD2: assert property (setp(timer_evt.update_two, 9))
        else $error("flag 9 not set");
    AST_WRAP: assert property (setp(timer_evt.counter_wrap, 8))
        else $error("flag 8 not set on wrap");
    AST_GEN: assert property (setp(timer_evt.update_one_generate && !timer_evt.update_disable, 8))
        else $error("flag 8 not set on generate");
    AST_OVR: assert property (cap0 ##1 cap0 ##1 rf |=> bus_rdata[4])
        else $error("over-capture not set");
    AST_CLR: assert property (rv0 && !cap0 && chan_evt.is_input[0] ##1 rf && !cap0 && chan_evt.is_input[0] |=> !bus_rdata[0])
        else $error("value read did not clear flag 0");
    AST_RSV: assert property (rf |=> bus_rdata[31:13] == 19'h0)
        else $error("reserved bits not zero");
    cover property (cap0 ##1 cap0);
    cover property (rv0 && chan_evt.is_input[0]);
    cover property ($rose(irq));
endmodule : tef_flags_sva

// *** verification/tef_flags_tb.sv ***
// Self-checking bench for the timer event flags block
`timescale 1ns/1ps
module tef_flags_tb;
    localparam logic [11:0] fl = tef_pkg::OFS_EVENT_FLAGS;
    localparam logic [11:0] mk = tef_pkg::OFS_EVENT_MASK;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tef_pkg::tef_bus_req_type req = '0;
    tef_pkg::tef_timer_evt_type tev = '0;
    tef_pkg::tef_chan_evt_type cev = '0;
    logic [63:0] cv = 64'h0;
    logic [31:0] rdata;
    logic irq;
    logic rd_q = 1'b0;
    logic [31:0] sd = 32'h9b7a;
    logic [31:0] q[$];
    int fails = 0;
    int checks = 0;
    int i;
    tef_flags u_tef_flags (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
        .timer_evt(tev), .chan_evt(cev), .chan_value(cv), .irq(irq));
    always #50 clk = ~clk;
    function automatic logic [31:0] lf(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lf
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One bus cycle plus events; on a read d is the expected data
    task automatic st(logic [1:0] op, logic [11:0] a, logic [31:0] d, logic [8:0] t,
        logic [12:0] c);
        req <= '{a, d, op[1], op[0]};
        tev <= t;
        cev <= c;
        if (op[0]) q.push_back(d);
        @(posedge clk);
    endtask : st
    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        rd_q <= req.rd;
        if (rd_q) chk("bus_rdata", rdata, q.pop_front());
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        sd = lf(sd);
        cv <= {sd, lf(sd)};
        st(1, fl, 0, 0, 0);
        st(1, mk, 0, 0, 0);
        st(1, 12'h3fc, 0, 0, 0);
        for (i = 0; i < 5; i++) begin
            st(0, 0, 0, 9'h100 >> i, 0);
            st(1, fl, 32'h1f00 & ~(32'h0fff >> i), 0, 0);
        end
        st(2, fl, 32'hffff_ffff, 0, 0);
        st(1, fl, 32'h1f00, 0, 0);
        st(2, fl, 0, 0, 0);
        st(1, fl, 0, 0, 0);
        $display("timer flags done");
        st(0, 0, 0, 9'h00c, 0);
        st(1, fl, 0, 0, 0);
        st(0, 0, 0, 9'h008, 0);
        st(1, fl, 32'h100, 9'h002, 0);
        st(2, fl, 0, 9'h002, 0);
        st(0, 0, 0, 9'h003, 0);
        st(1, fl, 32'h100, 9'h003, 0);
        st(2, fl, 0, 0, 0);
        $display("update flags done");
        st(0, 0, 0, 0, 13'h1e20);
        st(0, 0, 0, 0, 13'h1e20);
        st(1, fl, 32'h11, 0, 13'h1e00);
        st(1, tef_pkg::OFS_CH0_VALUE, {16'h0, cv[15:0]}, 0, 13'h1e00);
        st(1, fl, 32'h10, 0, 13'h1e00);
        st(2, fl, 0, 0, 0);
        st(0, 0, 0, 0, 13'h001e);
        st(1, fl, 32'hf, 0, 0);
        st(2, fl, 0, 0, 0);
        st(0, 0, 0, 0, 13'h001f);
        st(1, fl, 0, 0, 0);
        $display("channel flags done");
        st(2, fl, 0, 9'h040, 0);
        st(1, fl, 32'h400, 0, 0);
        st(2, mk, 32'h400, 0, 0);
        st(1, mk, 32'h400, 0, 0);
        chk("irq", {31'h0, irq}, 32'h1);
        st(2, fl, 0, 0, 0);
        st(0, 0, 0, 0, 0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("interrupt done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule : tef_flags_tb
bind tef_flags tef_flags_sva u_tef_flags_sva (.clk(clk), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_evt(timer_evt), .chan_evt(chan_evt),
    .chan_value(chan_value), .irq(irq));
